// ---- awd_defs.svh ----
// offsets, field positions, reset values and timing counts of the window detector
//=============================================================
// Operation
// - compare every new result against limits
// - matching result sets window match flag
// - match flag readable for polling
// - limits held as writable high/low bytes
// - limit order selects inside or outside
// - low limit high byte at C7, reset zero
// - conversion lasts 16 SAR clocks, then compare
// - justify bit selects result word layout
`ifndef AWD_DEFS_SVH
`define AWD_DEFS_SVH
//=============================================================
// special-function addresses, page 0
`define AWD_ADDR_CTRL     8'hE8
`define AWD_ADDR_RES_LO   8'hBE
`define AWD_ADDR_RES_HI   8'hBF
`define AWD_ADDR_GT_LO    8'hC4
`define AWD_ADDR_GT_HI    8'hC5
`define AWD_ADDR_LT_LO    8'hC6
`define AWD_ADDR_LT_HI    8'hC7
`define AWD_SFR_PAGE      8'h00
//=============================================================
// control register fields and reset values
`define AWD_BIT_WMATCH    1
`define AWD_BIT_LJUST     0
`define AWD_CTRL_RST      8'h00
`define AWD_LIMIT_RST     8'h00
//=============================================================
// timing
`define AWD_CONV_SAR_CLKS 16
`endif

// ---- awd_pkg.sv ----
// types shared by the window detector files
`default_nettype none
package awd_pkg;
  // register bus request
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } awd_sfr_req_t;
  // conversion sequencer states
  typedef enum logic [1:0] {
    AWD_IDLE,
    AWD_CONV,
    AWD_DONE
  } awd_state_t;
endpackage : awd_pkg
`default_nettype wire

// ---- awd_conv_timer.sv ----
// counts SAR clock enables through one conversion
`timescale 1ns/1ps
`default_nettype none
`include "awd_defs.svh"
module awd_conv_timer #(
  parameter int CONV_CLKS = `AWD_CONV_SAR_CLKS
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // control
  input  wire logic start,
  input  wire logic sarTick,
  // status
  output logic      busy,
  output logic      done
);
  //=============================================================
  // counter
  logic [4:0] count_r; // sar clocks elapsed

  // busy runs until the last SAR clock of the conversion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy    <= 1'b0;
      done    <= 1'b0;
      count_r <= 5'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy    <= 1'b1;
        count_r <= 5'h00;
      end else if (busy && sarTick) begin
        if (count_r == 5'(CONV_CLKS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_r <= count_r + 5'h01;
        end
      end
    end
  end
endmodule : awd_conv_timer
`default_nettype wire

// ---- awd_window_detector.sv ----
// window detector: limit registers, result formatting and compare
`timescale 1ns/1ps
`default_nettype none
`include "awd_defs.svh"
module awd_window_detector #(
  parameter int SAR_DIV   = 8,
  parameter int CONV_CLKS = `AWD_CONV_SAR_CLKS
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  // special-function bus
  input  wire awd_pkg::awd_sfr_req_t sfrReq,
  output logic [7:0]                 sfrRdata,
  // converter side
  input  wire logic                  convStart,
  input  wire logic [11:0]           convCode,
  input  wire logic                  convDiff,
  // status outputs
  output logic                       convBusy,
  output logic                       windowIrq
);
  //=============================================================
  // registers
  logic [7:0]  ctrl_r;        // converter_control_reg
  logic [7:0]  gtHi_r;        // window_high_limit_high_byte
  logic [7:0]  gtLo_r;        // window_high_limit_low_byte
  logic [7:0]  ltHi_r;        // window_low_limit_high_byte
  logic [7:0]  ltLo_r;        // window_low_limit_low_byte
  logic [15:0] result_r;      // formatted result word
  logic [7:0]  div_r;         // SAR clock divider
  logic        sarTick;       // one-cycle SAR enable
  logic        doneStb;       // conversion complete pulse
  logic        busyInt;       // conversion running
  logic [11:0] code_r;        // captured code
  logic        diff_r;        // captured polarity mode
  logic        cmpPend_r;     // result ready for compare
  logic        match;         // compare outcome
  logic        pageOk;        // bus on page 0

  assign pageOk = (sfrReq.page == `AWD_SFR_PAGE);

  function automatic logic [15:0] fmtWord(input logic [11:0] c, input logic d,
                                          input logic lj);
    if (lj) begin
      fmtWord = {c, 4'h0};
    end else begin
      fmtWord = {{4{d & c[11]}}, c};
    end
  endfunction

  // ordering in active sign format
  function automatic logic lessThan(input logic [15:0] a, input logic [15:0] b,
                                    input logic sgn);
    if (sgn) begin
      lessThan = $signed(a) < $signed(b);
    end else begin
      lessThan = a < b;
    end
  endfunction

  //=============================================================
  // SAR clock divider; plain counter, no gated clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      div_r   <= 8'h00;
      sarTick <= 1'b0;
    end else if (div_r == 8'(SAR_DIV - 1)) begin
      div_r   <= 8'h00;
      sarTick <= 1'b1;
    end else begin
      div_r   <= div_r + 8'h01;
      sarTick <= 1'b0;
    end
  end

  // conversion sequencer
  awd_conv_timer #(
    .CONV_CLKS (CONV_CLKS)
  ) uTimer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .start   (convStart),
    .sarTick (sarTick),
    .busy    (busyInt),
    .done    (doneStb)
  );

  //=============================================================
  // capture code at start; held through conversion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      code_r <= 12'h000;
      diff_r <= 1'b0;
    end else if (convStart && !busyInt) begin
      code_r <= convCode;
      diff_r <= convDiff;
    end
  end

  // result word and compare request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result_r  <= 16'h0000;
      cmpPend_r <= 1'b0;
    end else begin
      cmpPend_r <= doneStb;
      if (doneStb) begin
        result_r <= fmtWord(code_r, diff_r, ctrl_r[`AWD_BIT_LJUST]);
      end
    end
  end

  //=============================================================
  // window compare
  always_comb begin
    logic [15:0] gtW;
    logic [15:0] ltW;
    gtW = {gtHi_r, gtLo_r};
    ltW = {ltHi_r, ltLo_r};
    // limit order picks inside or outside
    if (lessThan(gtW, ltW, diff_r)) begin
      match = lessThan(gtW, result_r, diff_r) && lessThan(result_r, ltW, diff_r);
    end else begin
      match = lessThan(result_r, ltW, diff_r) || lessThan(gtW, result_r, diff_r);
    end
  end

  //=============================================================
  // control register; set wins over a clearing write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= `AWD_CTRL_RST;
    end else begin
      if (sfrReq.wrEn && pageOk && sfrReq.addr == `AWD_ADDR_CTRL) begin
        // software clears flag by writing zero
        ctrl_r <= sfrReq.wdata;
      end
      if (cmpPend_r && match) begin
        ctrl_r[`AWD_BIT_WMATCH] <= 1'b1;
      end
    end
  end

  // limit bytes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gtHi_r <= `AWD_LIMIT_RST;
      gtLo_r <= `AWD_LIMIT_RST;
      ltHi_r <= `AWD_LIMIT_RST;
      ltLo_r <= `AWD_LIMIT_RST;
    end else if (sfrReq.wrEn && pageOk) begin
      // low limit high byte at C7
      case (sfrReq.addr)
        `AWD_ADDR_GT_HI: gtHi_r <= sfrReq.wdata;
        `AWD_ADDR_GT_LO: gtLo_r <= sfrReq.wdata;
        `AWD_ADDR_LT_HI: ltHi_r <= sfrReq.wdata;
        `AWD_ADDR_LT_LO: ltLo_r <= sfrReq.wdata;
        default: ;
      endcase
    end
  end

  //=============================================================
  // read data, registered; unmapped reads zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sfrRdata <= 8'h00;
    end else if (sfrReq.rdEn && pageOk) begin
      case (sfrReq.addr)
        `AWD_ADDR_CTRL:   sfrRdata <= ctrl_r;
        `AWD_ADDR_RES_HI: sfrRdata <= result_r[15:8];
        `AWD_ADDR_RES_LO: sfrRdata <= result_r[7:0];
        `AWD_ADDR_GT_HI:  sfrRdata <= gtHi_r;
        `AWD_ADDR_GT_LO:  sfrRdata <= gtLo_r;
        `AWD_ADDR_LT_HI:  sfrRdata <= ltHi_r;
        `AWD_ADDR_LT_LO:  sfrRdata <= ltLo_r;
        default:          sfrRdata <= 8'h00;
      endcase
    end else begin
      sfrRdata <= 8'h00;
    end
  end

  // status outputs from flops
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      convBusy  <= 1'b0;
      windowIrq <= 1'b0;
    end else begin
      convBusy  <= busyInt;
      windowIrq <= ctrl_r[`AWD_BIT_WMATCH];
    end
  end

  //=============================================================
  // checks
  // match sets flag
  flag_on_match_a: assert property (@(posedge ref_clk) disable iff (srst)
    cmpPend_r && match |=> ctrl_r[`AWD_BIT_WMATCH])
    else $error("match did not set flag");
  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (srst)
    ctrl_r[`AWD_BIT_WMATCH] && !(sfrReq.wrEn && sfrReq.addr == `AWD_ADDR_CTRL)
    |=> ctrl_r[`AWD_BIT_WMATCH])
    else $error("flag cleared by hardware");
  compare_timing_a: assert property (@(posedge ref_clk) disable iff (srst)
    doneStb |=> cmpPend_r)
    else $error("compare missed after done");
  // polled flag follows into irq
  // the edge after a reset is skipped: the copy was cleared, not copied
  irq_follows_a: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(srst) |-> windowIrq == $past(ctrl_r[`AWD_BIT_WMATCH]))
    else $error("irq does not track flag");
  // low limit high byte write lands
  lt_high_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    sfrReq.wrEn && pageOk && sfrReq.addr == `AWD_ADDR_LT_HI |=> ltHi_r == $past(sfrReq.wdata))
    else $error("limit byte not written");
  left_justify_a: assert property (@(posedge ref_clk) disable iff (srst)
    doneStb && ctrl_r[`AWD_BIT_LJUST] |=> result_r[3:0] == 4'h0)
    else $error("left justify nibble not zero");
  no_false_match_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(ctrl_r[`AWD_BIT_WMATCH]) |-> $past(cmpPend_r && match)
      || $past(sfrReq.wrEn && sfrReq.addr == `AWD_ADDR_CTRL))
    else $error("flag set without cause");
  // busy lasts eight ref_clk cycles at least
  busy_length_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(busyInt) |-> busyInt[*8])
    else $error("conversion ended early");
endmodule : awd_window_detector
`default_nettype wire

// ---- awd_conv_model.sv ----
// behavioural converter front end feeding raw codes to the window detector
`timescale 1ns/1ps
`default_nettype none
module awd_conv_model (
  // clock
  input  wire logic   ref_clk,
  // converter result side
  output logic        convStart,
  output logic [11:0] convCode,
  output logic        convDiff
);
  //==========================================================
  // idle levels
  initial begin
    convStart = 1'b0;
    convCode  = 12'h5a5;
    convDiff  = 1'b0;
  end

  //==========================================================
  // one start pulse; code is only valid at the sampling edge
  task automatic convert(input logic [11:0] code, input logic diff);
    @(posedge ref_clk);
    #1;
    convStart = 1'b1;
    convCode  = code;
    convDiff  = diff;
    @(posedge ref_clk);
    #1;
    convStart = 1'b0;
    // released lines show garbage so a late sample is caught
    convCode  = ~code;
  endtask
endmodule // awd_conv_model
`default_nettype wire

// ---- tb_awd_window_detector.sv ----
// self-checking bench for the window detector
`timescale 1ns/1ps
`default_nettype none
`include "awd_defs.svh"
module tb_awd_window_detector;
  // one table row: clear, diff, justify, code, limits, expected flag
  typedef struct packed {
    logic clr; logic diff; logic lj; logic [11:0] code;
    logic [15:0] gt; logic [15:0] lt; logic exp;
  } awd_case_t;
  logic                  ref_clk;
  logic                  srst;
  awd_pkg::awd_sfr_req_t sfrReq;
  logic [7:0]            sfrRdata;
  logic                  convStart;
  logic [11:0]           convCode;
  logic                  convDiff;
  logic                  convBusy;
  logic                  windowIrq;
  logic [7:0]            rd;
  logic [15:0]           res;
  int                    errors;
  int                    checks;
  int                    cycles;
  int                    n;
  awd_case_t             tc [8];

  // short SAR divider keeps each conversion near 16 cycles
  awd_window_detector #(.SAR_DIV(1), .CONV_CLKS(`AWD_CONV_SAR_CLKS)) i_awd_window_detector (
    .ref_clk(ref_clk), .srst(srst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .convStart(convStart), .convCode(convCode), .convDiff(convDiff),
    .convBusy(convBusy), .windowIrq(windowIrq));
  awd_conv_model i_awd_conv_model (
    .ref_clk(ref_clk), .convStart(convStart), .convCode(convCode), .convDiff(convDiff));

  //==========================================================
  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  //==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle; read data lands the cycle after the request
  task automatic sfr(input logic wr, input logic [7:0] pg, input logic [7:0] ad,
                     input logic [7:0] wd, output logic [7:0] rdat);
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: wr, rdEn: !wr, page: pg, addr: ad, wdata: wd};
    @(posedge ref_clk);
    #1;
    sfrReq = '0;
    rdat = sfrRdata;
  endtask
  task automatic print_verdict();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  //==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    sfrReq = '0;
    errors = 0;
    checks = 0;
    cycles = 0;
    tc = '{
      {1'b1, 1'b0, 1'b0, 12'h080, 16'h0200, 16'h0100, 1'b1},
      {1'b0, 1'b0, 1'b0, 12'h150, 16'h0200, 16'h0100, 1'b1},
      {1'b1, 1'b0, 1'b0, 12'h150, 16'h0100, 16'h0200, 1'b1},
      {1'b1, 1'b0, 1'b0, 12'h200, 16'h0100, 16'h0200, 1'b0},
      {1'b1, 1'b1, 1'b0, 12'hfff, 16'hff00, 16'h0100, 1'b1},
      {1'b1, 1'b1, 1'b0, 12'h800, 16'hff00, 16'h0100, 1'b0},
      {1'b1, 1'b0, 1'b1, 12'h800, 16'h7ff0, 16'h0010, 1'b1},
      {1'b1, 1'b1, 1'b1, 12'h7ff, 16'h7ff0, 16'h8000, 1'b0}};
    repeat (5) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    // reset values of every register
    // sweep covers result, unmapped and all four limit bytes
    for (int i = 0; i < 10; i++) begin
      sfr(1'b0, 8'h00, 8'hbe + 8'(i), 8'h00, rd);
      check(rd, 8'h00);
    end
    sfr(1'b0, 8'h00, `AWD_ADDR_CTRL, 8'h00, rd);
    check(rd, 8'h00);
    // limit byte storage, other pages and unmapped places
    sfr(1'b1, 8'h00, `AWD_ADDR_LT_HI, 8'h5a, rd);
    sfr(1'b1, 8'h01, `AWD_ADDR_LT_HI, 8'h33, rd);
    sfr(1'b0, 8'h00, `AWD_ADDR_LT_HI, 8'h00, rd);
    check(rd, 8'h5a);
    sfr(1'b0, 8'h01, `AWD_ADDR_LT_HI, 8'h00, rd);
    check(rd, 8'h00);
    sfr(1'b0, 8'h00, 8'hc0, 8'h00, rd);
    check(rd, 8'h00);
    // window table: limits, conversion, flag, result layout
    foreach (tc[i]) begin
      if (tc[i].clr) begin
        sfr(1'b1, 8'h00, `AWD_ADDR_CTRL, {7'h00, tc[i].lj}, rd);
      end
      sfr(1'b1, 8'h00, `AWD_ADDR_GT_HI, tc[i].gt[15:8], rd);
      sfr(1'b1, 8'h00, `AWD_ADDR_GT_LO, tc[i].gt[7:0], rd);
      sfr(1'b1, 8'h00, `AWD_ADDR_LT_HI, tc[i].lt[15:8], rd);
      sfr(1'b1, 8'h00, `AWD_ADDR_LT_LO, tc[i].lt[7:0], rd);
      sfr(1'b0, 8'h00, `AWD_ADDR_LT_LO, 8'h00, rd);
      check(rd, tc[i].lt[7:0]);
      i_awd_conv_model.convert(tc[i].code, tc[i].diff);
      // busy shows one cycle after the start edge; wait for it first
      n = 0;
      while (convBusy !== 1'b1 && n < 8) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      // count busy cycles; divider of one gives one SAR clock a cycle
      n = 0;
      while (convBusy === 1'b1 && n < 200) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check(8'(n), 8'(`AWD_CONV_SAR_CLKS));
      repeat (4) @(posedge ref_clk);
      #1;
      check({7'h00, windowIrq}, {7'h00, tc[i].exp});
      sfr(1'b0, 8'h00, `AWD_ADDR_CTRL, 8'h00, rd);
      check(rd, {6'h00, tc[i].exp, tc[i].lj});
      res = tc[i].lj ? {tc[i].code, 4'h0} : {{4{tc[i].diff & tc[i].code[11]}}, tc[i].code};
      sfr(1'b0, 8'h00, `AWD_ADDR_RES_HI, 8'h00, rd);
      check(rd, res[15:8]);
      sfr(1'b0, 8'h00, `AWD_ADDR_RES_LO, 8'h00, rd);
      check(rd, res[7:0]);
    end
    // mid-run reset with flag raised and a limit loaded
    sfr(1'b1, 8'h00, `AWD_ADDR_CTRL, 8'h02, rd);
    sfr(1'b1, 8'h00, `AWD_ADDR_LT_HI, 8'ha5, rd);
    repeat (2) @(posedge ref_clk);
    #1;
    check({7'h00, windowIrq}, 8'h01);
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    check({7'h00, windowIrq}, 8'h00);
    sfr(1'b0, 8'h00, `AWD_ADDR_LT_HI, 8'h00, rd);
    check(rd, 8'h00);
    sfr(1'b0, 8'h00, `AWD_ADDR_CTRL, 8'h00, rd);
    check(rd, 8'h00);
    print_verdict();
  end
endmodule // tb_awd_window_detector
`default_nettype wire
